// ==== bench/hbcdf_host_model.sv ====
// Purpose: Bus master model that issues host reads and command writes.
// Assumes: The ready wire is pulled high while the device does not drive.
// Notes: Strobes change just after a rising edge and are held until done.
`default_nettype none
module hbcdf_host_model (
  input wire logic clk,
  input wire logic readyWireN,
  input wire logic writeAllowed,
  output logic chipSelect,
  output logic readN,
  output logic [3:0] writeN
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // Idle bus.
  // -----------------------------------------------------------------
  initial begin
    chipSelect = 1'b0;
    readN = 1'b1;
    writeN = 4'hF;
  end
  // One read; lowCycles counts the cycles the wait was seen low.
  task automatic readAccess(output int lowCycles);
    int i;
    lowCycles = 0;
    @(posedge clk);
    chipSelect <= 1'b1;
    readN <= 1'b0;
    // A bounded wait, so a dead device cannot stall the master.
    for (i = 0; i < 12 && readyWireN !== 1'b0; i++) @(posedge clk) #1;
    while (readyWireN === 1'b0 && lowCycles < 40) begin
      @(posedge clk) #1;
      lowCycles++;
    end
    @(posedge clk);
    chipSelect <= 1'b0;
    readN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // One command write; polls the allowed flag unless told not to.
  task automatic writeAccess(input bit ignoreFlag);
    int i;
    for (i = 0; i < 50 && !ignoreFlag && writeAllowed !== 1'b1; i++)
      @(posedge clk) #1;
    @(posedge clk);
    chipSelect <= 1'b1;
    writeN <= 4'h0;
    repeat (6) @(posedge clk);
    chipSelect <= 1'b0;
    writeN <= 4'hF;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/test_host_bus_command_dma_flow.sv ====
// Purpose: Self-checking bench for host bus ready, command flow and DMA.
// Assumes: Ready timeout shortened to a small count for a quick run.
// Notes: Expected DMA sizes are worked out here from load and limits.
`default_nettype none
module test_host_bus_command_dma_flow;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 8;
  logic clk, reset, rdy, busy, ovfClr, cmdWr, allowed, ovf;
  logic readyN, readyOe, timedOut, cs, rdN, readyWireN;
  logic [3:0] wrN;
  logic en [2];
  logic wd [2];
  logic req [2];
  logic [7:0] ld [2];
  logic [7:0] lim [2];
  logic [7:0] left [2];
  int nFail = 0;
  int samplesChecked = 0;
  int nCmd = 0;
  int lc, i, base;
  // The pin floats high through its pull-up when not driven.
  assign readyWireN = readyOe ? readyN : 1'b1;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  hbcdf_host_model i_host (.clk(clk), .readyWireN(readyWireN),
    .writeAllowed(allowed), .chipSelect(cs), .readN(rdN), .writeN(wrN));
  hbcdf_host_bus_interface #(.READY_TIMEOUT(TO)) i_dut (
    .clk(clk), .reset(reset), .host_chip_select(cs),
    .host_read_strobe_n(rdN), .host_byte_write_strobes_n(wrN),
    .readDataReady(rdy), .host_bus_ready_n(readyN),
    .host_bus_ready_oe(readyOe), .readTimedOut(timedOut),
    .commandPipeBusy(busy), .commandWrite(cmdWr),
    .command_write_allowed_flag(allowed),
    .command_overflow_error_flag(ovf), .overflowClear(ovfClr),
    .inDmaEnable(en[1]), .inFifoLoad(ld[1]),
    .input_dma_low_limit(lim[1]), .inWordDone(wd[1]),
    .inDmaRequest(req[1]), .inWordsLeft(left[1]),
    .outDmaEnable(en[0]), .outFifoLoad(ld[0]),
    .output_dma_upper_limit(lim[0]), .outWordDone(wd[0]),
    .outDmaRequest(req[0]), .outWordsLeft(left[0]));
  // Counts command pulses handed on to the command controller.
  always @(posedge clk) if (cmdWr === 1'b1) nCmd <= nCmd + 1;
  // -----------------------------------------------------------------
  // Checking helpers.
  // -----------------------------------------------------------------
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Burst size, or zero where no start condition holds.
  function automatic int expSize(bit isIn, int load, int limit);
    if (isIn) return (load <= limit) ? hbcdf_pkg::IN_FIFO_WORDS - load : 0;
    return (load >= limit) ? load : 0;
  endfunction
  // One demand burst on a channel: 1 is input, 0 is output.
  task automatic dmaRun(bit c, int load, int limit);
    int n;
    n = expSize(c, load, limit);
    @(posedge clk);
    ld[c] <= load[7:0];
    lim[c] <= limit[7:0];
    en[c] <= 1'b1;
    @(posedge clk) #1;
    check("dmaRequest", {7'h00, n > 0}, {7'h00, req[c]});
    if (n > 0) begin
      check("wordsLeft", n[7:0], left[c]);
      repeat (n - 1) begin
        @(posedge clk) wd[c] <= 1'b1;
        @(posedge clk) wd[c] <= 1'b0;
      end
      @(posedge clk) #1;
      check("wordsLeft", 8'h01, left[c]);
      @(posedge clk) wd[c] <= 1'b1;
      // The last word ends the burst; enable drops only afterwards.
      @(posedge clk) begin
        wd[c] <= 1'b0;
        en[c] <= 1'b0;
      end
      #1;
      check("wordsLeft", 8'h00, left[c]);
      check("dmaRequest", 8'h00, {7'h00, req[c]});
    end else begin
      @(posedge clk) #1;
      check("dmaRequest", 8'h00, {7'h00, req[c]});
      @(posedge clk) en[c] <= 1'b0;
    end
  endtask
  // -----------------------------------------------------------------
  // Main sequence.
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h778B0B87));
    reset = 1'b1;
    {rdy, busy, ovfClr} = 3'h0;
    for (i = 0; i < 2; i++) begin
      {en[i], wd[i]} = 2'h0;
      ld[i] = 8'h00;
      lim[i] = 8'h00;
    end
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    fork
      i_host.readAccess(lc);
      begin
        repeat (8) @(posedge clk);
        rdy <= 1'b1;
        @(posedge clk) rdy <= 1'b0;
      end
    join
    check("waitSeen", 8'h01, {7'h00, lc > 0 && lc < 6});
    check("readTimedOut", 8'h00, {7'h00, timedOut});
    i_host.readAccess(lc);
    check("timeoutLen", 8'h01, {7'h00, lc >= TO - 1 && lc <= TO + 2});
    check("readTimedOut", 8'h01, {7'h00, timedOut});
    $display("Read tests done");
    base = nCmd;
    i_host.writeAccess(1'b0);
    check("commands", 8'h01, 8'(nCmd - base));
    check("overflow", 8'h00, {7'h00, ovf});
    busy <= 1'b1;
    @(posedge clk) #1;
    check("allowed", 8'h00, {7'h00, allowed});
    i_host.writeAccess(1'b1);
    check("overflow", 8'h01, {7'h00, ovf});
    check("commands", 8'h02, 8'(nCmd - base));
    busy <= 1'b0;
    i_host.writeAccess(1'b0);
    check("commands", 8'h03, 8'(nCmd - base));
    check("overflow", 8'h01, {7'h00, ovf});
    ovfClr <= 1'b1;
    @(posedge clk) ovfClr <= 1'b0;
    repeat (2) @(posedge clk) #1;
    check("overflow", 8'h00, {7'h00, ovf});
    // A faulty write while a clear is held: the set must win.
    busy <= 1'b1;
    ovfClr <= 1'b1;
    fork
      i_host.writeAccess(1'b1);
      begin
        @(posedge cmdWr) #1;
        check("overflowWins", 8'h01, {7'h00, ovf});
      end
    join
    check("overflowCleared", 8'h00, {7'h00, ovf});
    ovfClr <= 1'b0;
    busy <= 1'b0;
    $display("Command tests done");
    dmaRun(1'b1, 128, 128);
    dmaRun(1'b1, 100, 127);
    dmaRun(1'b0, 0, 0);
    dmaRun(1'b0, 128, 128);
    dmaRun(1'b1, 0, 0);
    for (i = 0; i < 24; i++) begin
      // Limits kept inside the allowed settings.
      dmaRun(1'b1, $urandom_range(128), $urandom_range(127));
      dmaRun(1'b0, $urandom_range(128), 1 + $urandom_range(127));
    end
    $display("DMA tests done");
    results();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #200000;
    nFail++;
    results();
  end
endmodule
`default_nettype wire

// ==== design/hbcdf_dma_channel.sv ====
// Purpose: One demand-mode DMA channel that sizes and counts a burst.
// Assumes: Load and limits come from logic on the same clock.
// Notes: A zero-sized burst is never started and the channel stays idle, so it never hangs.
`default_nettype none
module hbcdf_dma_channel #(
  parameter int LOAD_W = 8,
  parameter int FIFO_WORDS = 128,
  parameter bit IS_INPUT = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [LOAD_W-1:0] fifoLoad,
  input wire logic [LOAD_W-1:0] limit,
  input wire logic wordDone,
  output logic dmaRequest,
  output logic [LOAD_W-1:0] wordsLeft,
  output logic burstActive
);
  // ---------------------------------------------------------------
  // Start condition and burst size.
  // ---------------------------------------------------------------
  localparam logic [LOAD_W-1:0] FULL = LOAD_W'(FIFO_WORDS);
  hbcdf_pkg::hbcdf_dma_t state_q; // Channel state.
  logic [LOAD_W-1:0] count_q; // Words still to move in this burst.
  logic startHit; // Start condition seen this cycle.
  logic [LOAD_W-1:0] burstSize; // Size taken from the current load.

  // Input fills free space, output drains what is stored.
  always_comb begin
    if (IS_INPUT) begin
      startHit = fifoLoad <= limit;
      burstSize = FULL - fifoLoad;
    end else begin
      startHit = fifoLoad >= limit;
      burstSize = fifoLoad;
    end
  end

  // ---------------------------------------------------------------
  // Burst state and word counter.
  // ---------------------------------------------------------------
  // A size of zero is treated as an empty burst, not a stuck one.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= hbcdf_pkg::DMA_IDLE;
      count_q <= hbcdf_pkg::COUNT_RST;
    end else begin
      unique case (state_q)
        hbcdf_pkg::DMA_IDLE: begin
          if (enable && startHit && burstSize != '0) begin
            state_q <= hbcdf_pkg::DMA_BURST;
            count_q <= burstSize;
          end
        end
        hbcdf_pkg::DMA_BURST: begin
          if (!enable) begin
            state_q <= hbcdf_pkg::DMA_IDLE;
            count_q <= hbcdf_pkg::COUNT_RST;
          end else if (wordDone) begin
            count_q <= count_q - 1'b1;
            if (count_q == LOAD_W'(1)) begin
              state_q <= hbcdf_pkg::DMA_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign burstActive = state_q == hbcdf_pkg::DMA_BURST;
  assign dmaRequest = burstActive;
  assign wordsLeft = count_q;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  property p_no_hang;
    @(posedge clk) disable iff (reset)
      (!burstActive && enable && startHit && burstSize != '0)
      |=> burstActive && wordsLeft == $past(burstSize);
  endproperty
  a_no_hang: assert property (p_no_hang)
    else $error("DMA burst did not start on its condition.");

  property p_count;
    @(posedge clk) disable iff (reset)
      (burstActive && enable && wordDone && wordsLeft > LOAD_W'(1))
      |=> wordsLeft == $past(wordsLeft) - 1'b1;
  endproperty
  a_count: assert property (p_count)
    else $error("DMA word counter did not step.");

  property p_zero_idle;
    @(posedge clk) disable iff (reset)
      (!burstActive && burstSize == '0) |=> !burstActive;
  endproperty
  a_zero_idle: assert property (p_zero_idle)
    else $error("Zero-sized burst was started.");

  c_burst: cover property (@(posedge clk) disable iff (reset)
    burstActive ##1 !burstActive);
endmodule
`default_nettype wire

// ==== design/hbcdf_host_bus_interface.sv ====
// Purpose: Host bus read ready, command flow control and demand DMA.
// Assumes: Host strobes arrive from pins; FIFO status is on this clock.
// Notes: Overflow is only flagged; command flow is not repaired.
`default_nettype none
module hbcdf_host_bus_interface #(
  parameter int LOAD_W = hbcdf_pkg::LOAD_W,
  parameter int READY_TIMEOUT = hbcdf_pkg::READY_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_chip_select,
  input wire logic host_read_strobe_n,
  input wire logic [3:0] host_byte_write_strobes_n,
  input wire logic readDataReady,
  output logic host_bus_ready_n,
  output logic host_bus_ready_oe,
  output logic readTimedOut,
  input wire logic commandPipeBusy,
  output logic commandWrite,
  output logic command_write_allowed_flag,
  output logic command_overflow_error_flag,
  input wire logic overflowClear,
  input wire logic inDmaEnable,
  input wire logic [LOAD_W-1:0] inFifoLoad,
  input wire logic [LOAD_W-1:0] input_dma_low_limit,
  input wire logic inWordDone,
  output logic inDmaRequest,
  output logic [LOAD_W-1:0] inWordsLeft,
  input wire logic outDmaEnable,
  input wire logic [LOAD_W-1:0] outFifoLoad,
  input wire logic [LOAD_W-1:0] output_dma_upper_limit,
  input wire logic outWordDone,
  output logic outDmaRequest,
  output logic [LOAD_W-1:0] outWordsLeft
);
  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree.
  localparam int PINS = 6;
  logic [PINS-1:0] pinRaw; // Raw pin levels.
  logic [PINS-1:0] s1_q; // First stage, read only by the second.
  logic [PINS-1:0] s2_q; // Second stage.
  logic [PINS-1:0] s3_q; // Third stage.
  logic [PINS-1:0] pin_q; // Accepted pin levels.

  assign pinRaw = {host_chip_select, host_read_strobe_n,
                   host_byte_write_strobes_n};

  // Shift the pins through the three stages.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= 6'h1F;
      s2_q <= 6'h1F;
      s3_q <= 6'h1F;
    end else begin
      s1_q <= pinRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Take a new level only when the last two stages agree, which
  // filters single-cycle glitches from a noisy board.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_q <= 6'h1F;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic csOn; // Chip selected.
  logic readOn; // Read strobe active.
  logic writeOn; // Any write strobe active.
  assign csOn = pin_q[5];
  assign readOn = csOn && !pin_q[4];
  assign writeOn = csOn && (pin_q[3:0] != 4'hF);

  // ---------------------------------------------------------------
  // Read ready with timeout.
  // ---------------------------------------------------------------
  localparam int TW = $clog2(READY_TIMEOUT + 1);
  hbcdf_pkg::hbcdf_rd_t rd_q; // Read access state.
  logic [TW-1:0] wait_q; // Cycles spent waiting.
  logic timedOut_q; // Last read ended by timeout.

  // Wait while data is not ready; give up after the timeout.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_q <= hbcdf_pkg::RD_IDLE;
      wait_q <= '0;
      timedOut_q <= 1'b0;
    end else begin
      unique case (rd_q)
        hbcdf_pkg::RD_IDLE: begin
          wait_q <= '0;
          if (readOn) begin
            rd_q <= hbcdf_pkg::RD_WAIT;
            timedOut_q <= 1'b0;
          end
        end
        hbcdf_pkg::RD_WAIT: begin
          if (!readOn || readDataReady) begin
            rd_q <= hbcdf_pkg::RD_DONE;
          end else if (wait_q == TW'(READY_TIMEOUT - 1)) begin
            rd_q <= hbcdf_pkg::RD_DONE;
            timedOut_q <= 1'b1;
          end else begin
            wait_q <= wait_q + 1'b1;
          end
        end
        hbcdf_pkg::RD_DONE: begin
          // Hold released until the host ends the strobe.
          if (!readOn) begin
            rd_q <= hbcdf_pkg::RD_IDLE;
          end
        end
        default: begin
          // An unused state code falls back to idle with ready released,
          // so an upset state bit can never hold the host bus.
          rd_q <= hbcdf_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Drive the pin low only while waiting, high otherwise while chip
  // selected, so the bus is never held by a stuck wait.
  assign host_bus_ready_n = rd_q != hbcdf_pkg::RD_WAIT;
  assign host_bus_ready_oe = csOn;
  assign readTimedOut = timedOut_q;

  // ---------------------------------------------------------------
  // Command flow control.
  // ---------------------------------------------------------------
  logic writeOn_q; // Previous write strobe level.
  logic writeStart; // Rising edge of a write access.
  logic ovf_q; // Sticky overflow flag.
  logic cmdWr_q; // Registered command write pulse.
  assign writeStart = writeOn && !writeOn_q;

  // A write is passed on even when not allowed, so the command path
  // keeps running; only the flag records the fault.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      writeOn_q <= 1'b0;
      cmdWr_q <= 1'b0;
    end else begin
      writeOn_q <= writeOn;
      cmdWr_q <= writeStart;
    end
  end

  // Set wins over clear; only the software clear or reset clears it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovf_q <= 1'b0;
    end else if (writeStart && commandPipeBusy) begin
      ovf_q <= 1'b1;
    end else if (overflowClear) begin
      ovf_q <= 1'b0;
    end
  end

  assign commandWrite = cmdWr_q;
  assign command_write_allowed_flag = !commandPipeBusy;
  assign command_overflow_error_flag = ovf_q;

  // ---------------------------------------------------------------
  // Demand-mode DMA channels.
  // ---------------------------------------------------------------
  // The input FIFO size bounds the low limit setting.
  hbcdf_dma_channel #(
    .LOAD_W(LOAD_W),
    .FIFO_WORDS(hbcdf_pkg::IN_FIFO_WORDS),
    .IS_INPUT(1'b1)
  ) u_in (
    .clk(clk),
    .reset(reset),
    .enable(inDmaEnable),
    .fifoLoad(inFifoLoad),
    .limit(input_dma_low_limit),
    .wordDone(inWordDone),
    .dmaRequest(inDmaRequest),
    .wordsLeft(inWordsLeft),
    .burstActive()
  );

  hbcdf_dma_channel #(
    .LOAD_W(LOAD_W),
    .FIFO_WORDS(hbcdf_pkg::OUT_FIFO_WORDS),
    .IS_INPUT(1'b0)
  ) u_out (
    .clk(clk),
    .reset(reset),
    .enable(outDmaEnable),
    .fifoLoad(outFifoLoad),
    .limit(output_dma_upper_limit),
    .wordDone(outWordDone),
    .dmaRequest(outDmaRequest),
    .wordsLeft(outWordsLeft),
    .burstActive()
  );

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  property p_ready_wait;
    @(posedge clk) disable iff (reset)
      (rd_q == hbcdf_pkg::RD_IDLE && readOn) |=> !host_bus_ready_n;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("Ready not driven low at read start.");

  // The wait ends the cycle after the data is reported ready.
  property p_ready_release;
    @(posedge clk) disable iff (reset)
      (rd_q == hbcdf_pkg::RD_WAIT && readDataReady) |=> host_bus_ready_n;
  endproperty
  a_ready_release: assert property (p_ready_release)
    else $error("Ready not released when data was ready.");

  property p_timeout;
    @(posedge clk) disable iff (reset)
      (rd_q == hbcdf_pkg::RD_WAIT && readOn && !readDataReady &&
       wait_q == TW'(READY_TIMEOUT - 1))
      |=> host_bus_ready_n && readTimedOut;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Ready not released at timeout.");

  property p_bound;
    @(posedge clk) disable iff (reset)
      rd_q == hbcdf_pkg::RD_WAIT |-> wait_q < TW'(READY_TIMEOUT);
  endproperty
  a_bound: assert property (p_bound)
    else $error("Ready wait ran past its timeout.");

  property p_ovf_set;
    @(posedge clk) disable iff (reset)
      (writeStart && commandPipeBusy) |=> command_overflow_error_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("Overflow not recorded.");

  // A fault in the same cycle as a clear must not be lost, since
  // software would otherwise never learn of it.
  property p_ovf_win;
    @(posedge clk) disable iff (reset)
      (writeStart && commandPipeBusy && overflowClear)
      |=> command_overflow_error_flag;
  endproperty
  a_ovf_win: assert property (p_ovf_win)
    else $error("Overflow lost to a clear in the same cycle.");

  property p_ovf_sticky;
    @(posedge clk) disable iff (reset)
      (command_overflow_error_flag && !overflowClear)
      |=> command_overflow_error_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("Overflow flag cleared by itself.");

  property p_cmd_pass;
    @(posedge clk) disable iff (reset)
      writeStart |=> commandWrite ##1 !commandWrite;
  endproperty
  a_cmd_pass: assert property (p_cmd_pass)
    else $error("Command write not passed on.");

  c_read: cover property (@(posedge clk) disable iff (reset)
    !host_bus_ready_n ##1 host_bus_ready_n);
  c_timeout: cover property (@(posedge clk) disable iff (reset)
    $rose(readTimedOut));
  c_overflow: cover property (@(posedge clk) disable iff (reset)
    $rose(command_overflow_error_flag));
endmodule
`default_nettype wire

// ==== design/hbcdf_pkg.sv ====
// Purpose: Shared constants for the host bus command and DMA flow block.
// Assumes: One 200 MHz system clock, asynchronous active-high reset.
// Notes: Cycle counts derive from times given in nanoseconds.
`default_nettype none
package hbcdf_pkg;
  // ---------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------
  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 5;
  // Longest wait the ready pin may be held active, in nanoseconds.
  localparam int READY_TIMEOUT_NS = 2000;
  // Timeout as a count of cycles; a longest time rounds down.
  localparam int READY_TIMEOUT_CYC = READY_TIMEOUT_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // FIFO sizes.
  // ---------------------------------------------------------------
  // Input FIFO capacity in words.
  localparam int IN_FIFO_WORDS = 128;
  // Output FIFO capacity in words.
  localparam int OUT_FIFO_WORDS = 128;
  // Width of FIFO load and limit values.
  localparam int LOAD_W = 8;
  // Reset value of the word counters.
  localparam logic [LOAD_W-1:0] COUNT_RST = 8'h00;
  // Read access states.
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DONE} hbcdf_rd_t;
  // DMA channel states.
  typedef enum logic [0:0] {DMA_IDLE, DMA_BURST} hbcdf_dma_t;
endpackage
`default_nettype wire
